// ### flag_offset_regs.vh
// constants for the flag-offset parallel load and readback block
`ifndef FLAG_OFFSET_REGS_VH
`define FLAG_OFFSET_REGS_VH
// offset register widths: narrow base plus depth option, one more in 9-to-9
`define OFS_MAX_W 17
`define OFS_BASE_W 5'h0_00D
// reset value of both offsets until software loads them
`define EMPTY_OFS_RST 17'h0_007F
`define FULL_OFS_RST 17'h0_007F
// word pointer layout
`define PTR_W 3
`define PTR_RST 3'h0
// bit fields on a 9-bit lane: low byte, next byte, single top bit
`define LANE_BYTE_W 8
`define TOP_BIT 16
// fields on an 18-bit port with interspersed parity
`define HI_BYTE_LSB 9
`define HI_BYTE_MSB 16
// deepest depth option
`define DEPTH_DEEPEST 2'h3
`define PORT_W 18
`define COUNT_W 18
`endif

// ### flag_offset_port.v
// parallel load and readback of the empty and full flag offsets
`timescale 1ns/1ns
`include "flag_offset_regs.vh"
// Overview of operation
// RULE1 - load next offset word per write edge
// RULE2 - drive next offset word per read edge
// RULE3 - readback allowed whatever load method latched
// RULE4 - fall-through count includes output register word
// RULE5 - 9-to-9 offsets are 14 to 17 bits
// RULE6 - other widths offsets are 13 to 16
// RULE7 - bits above offset width are ignored
// RULE8 - 9-bit first word: empty bits 1-8
// RULE9 - 9-bit second word: empty bits 9-16
// RULE10 - deepest 9-to-9: third word carries bit 17
// RULE11 - six-word case: full offset same placement
// RULE12 - two-word case: words three, four full
// RULE13 - 9-in 18-out deepest load takes four
// RULE14 - 18-in 9-out deepest readback takes four
// RULE15 - deepest 9-to-9 takes six transfers
// RULE16 - 18-bit port: one word per offset
// RULE17 - pointer wraps after last offset word
// RULE18 - separate pointers, cleared by master reset
module flag_offset_port
(
  input wire clk, // system clock, 10 MHz
  input wire arst_n, // asynchronous reset, active low
  input wire master_reset_n, // master reset pin, latches the mode
  input wire input_width_select, // 1 = 18-bit write port, latched at master reset
  input wire output_width_select, // 1 = 18-bit read port, latched at master reset
  input wire [1:0] depth_select, // depth option, 0 smallest, latched at master reset
  input wire parity_intersperse, // 1 = interspersed parity, latched at master reset
  input wire fall_through_mode, // 1 = first-word fall-through, latched at master reset
  input wire load_method_select, // offset load method, latched, read back only
  input wire write_clk, // write clock pin, sampled
  input wire read_clk, // read clock pin, sampled
  input wire offset_load_select_n, // low selects offset registers
  input wire write_en_n, // write enable, active low
  input wire read_en_n, // read enable, active low
  input wire [17:0] data_in, // input data port
  input wire [17:0] mem_word_count, // words held in the memory array
  input wire out_reg_full, // output register holds a word
  output reg [17:0] data_out, // offset readback word
  output reg [16:0] empty_threshold_offset, // empty offset register
  output reg [16:0] full_threshold_offset, // full offset register
  output reg [17:0] flag_word_count, // word count for flag decisions
  output reg load_method_latched // load method caught at master reset
);
  // pin synchronisers: stage one is read only by stage two
  reg [22:0] sync1_ff;
  reg [22:0] sync2_ff;
  reg [6:0] strap_sync1_ff;
  reg [6:0] strap_sync2_ff;
  reg mrs_n_sync1_ff;
  reg mrs_n_sync2_ff;

  // previous clock-pin levels, for rising-edge detection
  reg wclk_prev_ff;
  reg rclk_prev_ff;

  // mode caught while master reset is low
  reg x18_in_ff;
  reg x18_out_ff;
  reg [1:0] depth_ff;
  reg parity_ff;
  reg fall_through_mode_ff;

  // word pointers, one per side so a readback never disturbs a load
  // values below words-per-offset walk the empty offset,
  // the rest of the count walks the full offset, then back to 0
  reg [2:0] wptr_ff;
  reg [2:0] rptr_ff;

  // decoded width, pointer end points and the part each pointer addresses
  reg [4:0] ofs_width;
  reg [16:0] ofs_mask;
  reg [2:0] wlast;
  reg [2:0] rlast;
  reg wfull;
  reg rfull;
  reg [1:0] wpart;
  reg [1:0] rpart;

  // load merge and readback placement
  reg [16:0] wnew;
  reg [16:0] wsel;
  reg [16:0] rsel;
  reg [17:0] rword;

  // synchronised pin views
  wire s_wclk;
  wire s_rclk;
  wire s_ld_n;
  wire s_wen_n;
  wire s_ren_n;
  wire [17:0] s_din;
  wire wedge;
  wire redge;

  // mode decode and the two access strobes
  wire nine_nine;
  wire [1:0] wpo_in;
  wire [1:0] wpo_out;
  wire offset_write;
  wire offset_read;

  // strap pins through two flops like any other pin; they settle long
  // before master reset ends, so the added delay costs nothing
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_sync1_ff <= 7'h00;
      strap_sync2_ff <= 7'h00;
    end
    else
    begin
      strap_sync1_ff <= {input_width_select, output_width_select, depth_select,
        parity_intersperse, fall_through_mode, load_method_select};
      strap_sync2_ff <= strap_sync1_ff;
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_ff <= 23'h00_0000;
      sync2_ff <= 23'h00_0000;
      wclk_prev_ff <= 1'b0;
      rclk_prev_ff <= 1'b0;
      mrs_n_sync1_ff <= 1'b0;
      mrs_n_sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {write_clk, read_clk, offset_load_select_n, write_en_n, read_en_n, data_in};
      sync2_ff <= sync1_ff;
      wclk_prev_ff <= sync2_ff[22];
      rclk_prev_ff <= sync2_ff[21];
      mrs_n_sync1_ff <= master_reset_n;
      mrs_n_sync2_ff <= mrs_n_sync1_ff;
    end
  end

  assign s_wclk = sync2_ff[22];
  assign s_rclk = sync2_ff[21];
  assign s_ld_n = sync2_ff[20];
  assign s_wen_n = sync2_ff[19];
  assign s_ren_n = sync2_ff[18];
  assign s_din = sync2_ff[17:0];
  assign wedge = s_wclk & ~wclk_prev_ff;
  assign redge = s_rclk & ~rclk_prev_ff;
  assign offset_write = wedge & ~s_ld_n & ~s_wen_n & s_ren_n; // see RULE1
  assign offset_read = redge & ~s_ld_n & ~s_ren_n & s_wen_n; // see RULE2 see RULE3
  assign nine_nine = ~x18_in_ff & ~x18_out_ff;
  // words per offset on each port: 1 on 18-bit, 2 on 9-bit, 3 if deepest 9-to-9
  // resulting walks, empty words first, full words after:
  //   18-bit port: two words in all
  //   9-bit port, offset up to 16 bits: low byte, high byte, four in all
  //   both ports narrow and deepest: three words each, six in all
  // only the deepest 9-to-9 mode has a 17th bit, so only it needs a third word
  // a narrow port beside a wide one keeps four words even when deepest
  assign wpo_in = x18_in_ff ? 2'h1 : ((nine_nine && depth_ff == `DEPTH_DEEPEST) ? 2'h3 : 2'h2);
  assign wpo_out = x18_out_ff ? 2'h1 : ((nine_nine && depth_ff == `DEPTH_DEEPEST) ? 2'h3 : 2'h2);

  // mode straps: held in while master reset is low, from the strap flops
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x18_in_ff <= 1'b0;
      x18_out_ff <= 1'b0;
      depth_ff <= 2'h0;
      parity_ff <= 1'b0;
      fall_through_mode_ff <= 1'b0;
      load_method_latched <= 1'b0;
    end
    else if (!mrs_n_sync2_ff)
    begin
      x18_in_ff <= strap_sync2_ff[6];
      x18_out_ff <= strap_sync2_ff[5];
      depth_ff <= strap_sync2_ff[4:3];
      parity_ff <= strap_sync2_ff[2];
      fall_through_mode_ff <= strap_sync2_ff[1];
      load_method_latched <= strap_sync2_ff[0]; // see RULE3
    end
  end

  // offset width and mask of meaningful bits
  always @*
  begin
    ofs_width = `OFS_BASE_W + {3'h0, depth_ff} + {4'h0, nine_nine}; // see RULE5 see RULE6
    ofs_mask = ~(17'h1_FFFF << ofs_width); // see RULE7
    wlast = {1'b0, wpo_in} + {1'b0, wpo_in} - 3'h1; // see RULE13 see RULE15 see RULE16
    rlast = {1'b0, wpo_out} + {1'b0, wpo_out} - 3'h1; // see RULE14 see RULE15
    wfull = (wptr_ff >= {1'b0, wpo_in});
    rfull = (rptr_ff >= {1'b0, wpo_out});
    wpart = wfull ? (wptr_ff[1:0] - wpo_in) : wptr_ff[1:0];
    rpart = rfull ? (rptr_ff[1:0] - wpo_out) : rptr_ff[1:0];
  end

  // load: merge incoming word into the addressed offset
  // untouched parts keep their old value, so a cut load sequence
  // leaves the rest of the offset as it was
  always @*
  begin
    wsel = wfull ? full_threshold_offset : empty_threshold_offset;
    wnew = wsel;
    if (x18_in_ff)
    begin
      if (parity_ff)
        wnew[15:0] = {s_din[`HI_BYTE_MSB:`HI_BYTE_LSB], s_din[7:0]}; // see RULE16
      else
        wnew[15:0] = s_din[15:0]; // see RULE16
    end
    else if (wpart == 2'h0)
      wnew[7:0] = s_din[7:0]; // see RULE8 see RULE12
    else if (wpart == 2'h1)
      wnew[15:8] = s_din[7:0]; // see RULE9 see RULE12
    else
      wnew[`TOP_BIT] = s_din[0]; // see RULE10 see RULE11
    wnew = wnew & ofs_mask; // see RULE7
  end

  // readback: place the addressed offset on the lanes
  // unused lanes read as zero rather than leftover data
  always @*
  begin
    rsel = rfull ? full_threshold_offset : empty_threshold_offset;
    rword = 18'h0_0000;
    if (x18_out_ff)
    begin
      if (parity_ff)
        rword = {1'b0, rsel[15:8], 1'b0, rsel[7:0]}; // see RULE16
      else
        rword = {2'h0, rsel[15:0]}; // see RULE16
    end
    else if (rpart == 2'h0)
      rword = {10'h000, rsel[7:0]}; // see RULE8 see RULE11
    else if (rpart == 2'h1)
      rword = {10'h000, rsel[15:8]}; // see RULE9 see RULE11
    else
      rword = {17'h0_0000, rsel[`TOP_BIT]}; // see RULE10 see RULE11
  end

  // offsets and load pointer; master reset restores defaults
  // refused pin combinations simply leave everything as it stands
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      empty_threshold_offset <= `EMPTY_OFS_RST;
      full_threshold_offset <= `FULL_OFS_RST;
      wptr_ff <= `PTR_RST;
    end
    else if (!mrs_n_sync2_ff)
    begin
      empty_threshold_offset <= `EMPTY_OFS_RST;
      full_threshold_offset <= `FULL_OFS_RST;
      wptr_ff <= `PTR_RST; // see RULE18
    end
    else if (offset_write)
    begin
      if (wfull)
        full_threshold_offset <= wnew;
      else
        empty_threshold_offset <= wnew;
      wptr_ff <= (wptr_ff == wlast) ? `PTR_RST : wptr_ff + 3'h1; // see RULE17
    end
  end

  // readback pointer runs apart from the load pointer
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rptr_ff <= `PTR_RST;
      data_out <= 18'h0_0000;
    end
    else if (!mrs_n_sync2_ff)
    begin
      rptr_ff <= `PTR_RST; // see RULE18
      data_out <= 18'h0_0000;
    end
    else if (offset_read)
    begin
      data_out <= rword; // see RULE2
      rptr_ff <= (rptr_ff == rlast) ? `PTR_RST : rptr_ff + 3'h1; // see RULE17
    end
  end

  // flag count: fall-through adds the word parked in the output register
  // registered, so the count trails its inputs by one clock
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_word_count <= 18'h0_0000;
    else
      flag_word_count <= mem_word_count + {17'h0_0000, fall_through_mode_ff & out_reg_full}; // see RULE4
  end
endmodule

// ### flag_offset_port_properties.sv
// checker for the flag-offset port block
`timescale 1ns/1ns
module flag_offset_port_properties
(
  input wire clk, // clock
  input wire arst_n, // reset
  input wire master_reset_n, // mode latch
  input wire input_width_select, // strap
  input wire output_width_select, // strap
  input wire [1:0] depth_select, // strap
  input wire fall_through_mode, // strap
  input wire write_en_n, // pin
  input wire read_en_n, // pin
  input wire [17:0] mem_word_count, // count in
  input wire out_reg_full, // held word
  input wire [17:0] data_out, // readback
  input wire [16:0] empty_threshold_offset, // offset
  input wire [16:0] full_threshold_offset, // offset
  input wire [17:0] flag_word_count // count out
);
  // width from the straps, only trusted once the mode latch has settled
  wire [4:0] w = 5'hd + depth_select + (!input_width_select && !output_width_select);
  wire [33:0] ofs = {empty_threshold_offset, full_threshold_offset};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_load_idle: assert property
    ((write_en_n && master_reset_n)[*5] |=> $stable(ofs)) else $error("offset moved");
  chk_read_idle: assert property
    ((read_en_n && master_reset_n)[*5] |=> $stable(data_out)) else $error("readback moved");
  chk_count_plain: assert property
    (!$past(out_reg_full) |-> flag_word_count == $past(mem_word_count)) else $error("count");
  chk_count_held: assert property
    (fall_through_mode && $past(out_reg_full) |-> flag_word_count == $past(mem_word_count) + 18'h1)
    else $error("held word not counted");
  chk_lane_idle: assert property
    (!output_width_select |-> data_out[17:8] == 10'h000) else $error("narrow lane");
  chk_empty_width: assert property
    (master_reset_n[*4] |-> (empty_threshold_offset >> w) == 17'h0) else $error("empty width");
  chk_full_width: assert property
    (master_reset_n[*4] |-> (full_threshold_offset >> w) == 17'h0) else $error("full width");
  chk_mrs_default: assert property
    (!master_reset_n[*4] |-> ofs == {17'h0_007F, 17'h0_007F}) else $error("default");
  cover property (!read_en_n && !output_width_select);
  cover property ($rose(master_reset_n));
  cover property (out_reg_full && fall_through_mode);
endmodule
bind flag_offset_port flag_offset_port_properties chk_i (.clk, .arst_n, .master_reset_n,
  .input_width_select, .output_width_select, .depth_select, .fall_through_mode, .write_en_n,
  .read_en_n, .mem_word_count, .out_reg_full, .data_out, .empty_threshold_offset,
  .full_threshold_offset, .flag_word_count);

// ### offset_host.sv
// host model driving the offset access pins
`timescale 1ns/1ns
module offset_host
(
  input wire clk, // clock
  output reg write_clk = 1'b0, // pin
  output reg read_clk = 1'b0, // pin
  output reg offset_load_select_n = 1'b1, // pin
  output reg write_en_n = 1'b1, // pin
  output reg read_en_n = 1'b1, // pin
  output reg [17:0] data_in = 18'h0 // bus
);
  // one access; pins held well past the input synchronisers
  task access(input rd, input [17:0] d);
    begin
      @(negedge clk);
      offset_load_select_n = 1'b0;
      write_en_n = rd;
      read_en_n = !rd;
      data_in = d;
      repeat (3) @(negedge clk);
      if (rd)
        read_clk = 1'b1;
      else
        write_clk = 1'b1;
      repeat (4) @(negedge clk);
      write_clk = 1'b0;
      read_clk = 1'b0;
      repeat (3) @(negedge clk);
      offset_load_select_n = 1'b1;
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      data_in = ~d; // released bus never keeps the old word
    end
  endtask
endmodule

// ### test_flag_offset_port.sv
// self-checking bench for the flag-offset port
`timescale 1ns/1ns
module test_flag_offset_port;
  reg clk = 1'b0, arst_n = 1'b0, master_reset_n = 1'b0, run = 1'b0;
  reg input_width_select = 1'b0, output_width_select = 1'b0, parity_intersperse = 1'b0;
  reg fall_through_mode = 1'b1, load_method_select = 1'b0, out_reg_full = 1'b0;
  reg [1:0] depth_select = 2'h0;
  reg [17:0] mem_word_count = 18'h0;
  reg [31:0] seed = 32'h0000_a296;
  wire write_clk, read_clk, offset_load_select_n, write_en_n, read_en_n, load_method_latched;
  wire [17:0] data_in, data_out, flag_word_count;
  wire [16:0] empty_threshold_offset, full_threshold_offset;
  integer err_total = 0, tests_run = 0;
  logic [17:0] exp_q[$], wq[$];
  flag_offset_port DUT (.clk, .arst_n, .master_reset_n, .input_width_select,
    .output_width_select, .depth_select, .parity_intersperse, .fall_through_mode,
    .load_method_select, .write_clk, .read_clk, .offset_load_select_n, .write_en_n, .read_en_n,
    .data_in, .mem_word_count, .out_reg_full, .data_out, .empty_threshold_offset,
    .full_threshold_offset, .flag_word_count, .load_method_latched);
  offset_host host (.clk, .write_clk, .read_clk, .offset_load_select_n, .write_en_n,
    .read_en_n, .data_in);
  always #50 clk = ~clk;
  function [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  task chk(input [17:0] got, input [17:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // word list for one offset on a port of the given width
  task fill(input wide, input nn, input [16:0] v);
    begin
      if (!wide)
      begin
        wq.push_back({10'h0, v[7:0]});
        wq.push_back({10'h0, v[15:8]});
        if (nn)
          wq.push_back({17'h0, v[16]});
      end
      else if (parity_intersperse)
        wq.push_back({1'b0, v[15:8], 1'b0, v[7:0]});
      else
        wq.push_back({2'h0, v[15:0]});
    end
  endtask
  // mode m = {in wide, out wide, depth, parity}: master reset, load, read back twice
  task run_mode(input [4:0] m);
    reg nn;
    reg [16:0] re, rf, msk;
    begin
      @(negedge clk);
      {input_width_select, output_width_select, depth_select, parity_intersperse} = m;
      load_method_select = seed[3];
      master_reset_n = 1'b0;
      repeat (6) @(negedge clk);
      master_reset_n = 1'b1;
      repeat (4) @(negedge clk);
      run = 1'b1;
      chk(empty_threshold_offset, 18'h7F);
      chk(full_threshold_offset, 18'h7F);
      chk(load_method_latched, load_method_select);
      nn = !m[4] && !m[3] && m[2:1] == 2'h3;
      msk = (17'h1 << (13 + m[2:1] + nn)) - 17'h1;
      re = seed[16:0];
      rf = seed[31:15];
      wq.delete();
      fill(m[4], nn, re);
      fill(m[4], nn, rf);
      // junk in the don't-care lanes and above the width must be dropped
      foreach (wq[i])
      begin
        seed = xs(seed);
        host.access(1'b0, wq[i] | seed[17:0] & (m[4] ? (m[0] ? 18'h2_0100 : 18'h3_0000)
          : 18'h3_FF00));
      end
      chk(empty_threshold_offset, re & msk);
      chk(full_threshold_offset, rf & msk);
      wq.delete();
      fill(m[3], nn, re & msk);
      fill(m[3], nn, rf & msk);
      repeat (2)
        foreach (wq[i])
        begin
          exp_q.push_back(wq[i]);
          host.access(1'b1, 18'h0);
        end
    end
  endtask
  // readback watcher: the word lands three clocks after the pin edge
  always @(posedge read_clk)
  begin
    repeat (5) @(posedge clk);
    #1;
    chk(data_out, exp_q.pop_front());
  end
  // random array count once a mode is latched
  always @(negedge clk)
  begin
    if (run)
    begin
      seed = xs(seed);
      mem_word_count <= seed[17:0];
      out_reg_full <= seed[18];
    end
  end
  // watchdog, about seven times the expected run
  initial
  begin
    #400000;
    err_total = err_total + 1;
    wrap_up;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    chk(empty_threshold_offset, 18'h7F);
    run_mode(5'h06);
    run_mode(5'h16);
    run_mode(5'h0E);
    run_mode(5'h18);
    run_mode(5'h1D);
    repeat (8) @(negedge clk);
    wrap_up;
  end
endmodule
